// file: hw/temp_sensor_access_alert.sv
// Temperature sensor digital core: serial slave, alert, conversion timing
`timescale 1ns/1ps

// Function
// - Write is address, pointer, one data byte
// - Pointer persists across any number of reads
// - Limit/config reads one byte, temperature two
// - Config D4 sets alert polarity, low default
// - Config D5 one disables alert
// - Alert output only sinks, open drain
// - Answer alert response address only while alerting
// - Alert set when temperature exceeds upper limit
// - Alert cleared by D3 write or low
// - Pointer selects temperature after reset
// - Reset loads limits 7F/80, config 40
// - Automatic conversion every 800 ms
// - One-shot converts now, schedule resumes
// - Result dropped if serial access active
// - Config D7 enters full power-down
// - Power-down one-shot wakes 4 us, converts
// - Serial interface works during power-down
// - Stay powered down until cleared; one-shot converts once, then sleeps
// - Temperature is 10-bit read-only at 0
// - Second byte high/low flags clear on read, alert flag stays
// - Upper limit register at pointer 2
// - Lower limit register at pointer 3
module temp_sensor_access_alert
   import temp_sensor_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT,
   parameter int PERIOD_CYC = CONV_PERIOD_CYC
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic clk_link_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n_o,
   output logic alert_o,
   output logic alert_oe_n_o,
   input wire logic [9:0] adc_code_i,
   output logic converter_on_o,
   output logic converting_o
);

   // ----------------------------------------------------------------
   // Link domain: pin synchronisers and bus events
   // ----------------------------------------------------------------
   logic scl_s1_ff, scl_s2_ff, scl_d_ff;
   logic sda_s1_ff, sda_s2_ff, sda_d_ff;
   logic scl_rise, scl_fall, bus_start, bus_stop;

   // Pins pass two flops; the edge stage only reads the second
   always_ff @(posedge clk_link_i or posedge rst_i) begin
      if (rst_i) begin
         scl_s1_ff <= 1'b1;
         scl_s2_ff <= 1'b1;
         scl_d_ff <= 1'b1;
         sda_s1_ff <= 1'b1;
         sda_s2_ff <= 1'b1;
         sda_d_ff <= 1'b1;
      end else begin
         scl_s1_ff <= scl_i;
         scl_s2_ff <= scl_s1_ff;
         scl_d_ff <= scl_s2_ff;
         sda_s1_ff <= sda_i;
         sda_s2_ff <= sda_s1_ff;
         sda_d_ff <= sda_s2_ff;
      end
   end

   // Data edges while clock is high frame the transfer
   assign scl_rise = scl_s2_ff & ~scl_d_ff;
   assign scl_fall = ~scl_s2_ff & scl_d_ff;
   assign bus_start = scl_s2_ff & scl_d_ff & ~sda_s2_ff & sda_d_ff;
   assign bus_stop = scl_s2_ff & scl_d_ff & sda_s2_ff & ~sda_d_ff;

   // ----------------------------------------------------------------
   // Link domain: protocol state
   // ----------------------------------------------------------------
   link_state_t state_ff;
   logic [3:0] bitcnt_ff;
   logic [7:0] rx_ff, tx_ff;
   logic rw_ff, ara_ff, mack_ff, busy_ff, sda_drv_ff;
   logic [1:0] byte_idx_ff;
   logic [1:0] ptr_ff;
   cfg_t cfg_ff;
   logic [7:0] high_ff, low_ff;
   logic [9:0] temp_ff;
   flags_t flags_ff;
   logic alert_act;
   logic addr_hit, ara_hit, wr_done, load_first, load_next;
   logic [7:0] tx_byte;

   // Alert as seen by the pin after the enable bit
   // disable gate
   assign alert_act = flags_ff.alert & ~cfg_ff.alert_dis;

   assign ara_hit = rx_ff[7:1] == ALERT_RESP_ADDR && rx_ff[0] && alert_act;
   assign addr_hit = rx_ff[7:1] == DEV_ADDR;
   assign wr_done = scl_fall && state_ff == LS_WR_BYTE
                    && bitcnt_ff == BITS_PER_BYTE;
   assign load_first = scl_fall && state_ff == LS_ADDR_ACK && rw_ff;
   assign load_next = scl_fall && state_ff == LS_RD_ACK && mack_ff;

   // Byte to send next, chosen by the pointer
   always_comb begin
      tx_byte = 8'h00;
      if (ara_ff) begin
         tx_byte = {DEV_ADDR, 1'b0};
      end else begin
         case (ptr_ff)
            PTR_TEMP: begin
               if (byte_idx_ff == 2'h0) begin
                  tx_byte = temp_ff[9:2];
               end else begin
                  tx_byte = {temp_ff[1:0], flags_ff, 3'b000};
               end
            end
            PTR_CFG: tx_byte = cfg_ff;
            PTR_HIGH: tx_byte = high_ff;
            PTR_LOW: tx_byte = low_ff;
            default: tx_byte = 8'h00;
         endcase
      end
   end

   // Slave protocol; the link runs whatever the power state
   // serial side never powered down
   always_ff @(posedge clk_link_i or posedge rst_i) begin
      if (rst_i) begin
         state_ff <= LS_IDLE;
         bitcnt_ff <= 4'h0;
         rx_ff <= 8'h00;
         tx_ff <= 8'h00;
         rw_ff <= 1'b0;
         ara_ff <= 1'b0;
         mack_ff <= 1'b0;
         sda_drv_ff <= 1'b0;
         byte_idx_ff <= 2'h0;
      end else if (bus_start) begin
         state_ff <= LS_ADDR;
         bitcnt_ff <= 4'h0;
         sda_drv_ff <= 1'b0;
         byte_idx_ff <= 2'h0;
         ara_ff <= 1'b0;
      end else if (bus_stop) begin
         state_ff <= LS_IDLE;
         sda_drv_ff <= 1'b0;
      end else if (scl_rise) begin
         rx_ff <= {rx_ff[6:0], sda_s2_ff};
         bitcnt_ff <= bitcnt_ff + 4'h1;
         if (state_ff == LS_RD_ACK) begin
            mack_ff <= ~sda_s2_ff;
         end
         // released one read back low, arbitration lost
         if (state_ff == LS_RD_BYTE && !sda_drv_ff && !sda_s2_ff) begin
            state_ff <= LS_IDLE;
         end
      end else if (scl_fall) begin
         case (state_ff)
            LS_ADDR: begin
               if (bitcnt_ff == BITS_PER_BYTE) begin
                  if (addr_hit || ara_hit) begin
                     sda_drv_ff <= 1'b1;
                     rw_ff <= rx_ff[0];
                     ara_ff <= ara_hit;
                     state_ff <= LS_ADDR_ACK;
                  end else begin
                     state_ff <= LS_IDLE;
                  end
               end
            end
            LS_ADDR_ACK: begin
               bitcnt_ff <= 4'h0;
               if (rw_ff) begin
                  sda_drv_ff <= ~tx_byte[7];
                  tx_ff <= {tx_byte[6:0], 1'b0};
                  state_ff <= LS_RD_BYTE;
               end else begin
                  sda_drv_ff <= 1'b0;
                  state_ff <= LS_WR_BYTE;
               end
            end
            LS_WR_BYTE: begin
               if (bitcnt_ff == BITS_PER_BYTE) begin
                  // pointer then one data byte, more refused
                  sda_drv_ff <= byte_idx_ff != 2'h2;
                  state_ff <= LS_WR_ACK;
                  if (byte_idx_ff != 2'h2) begin
                     byte_idx_ff <= byte_idx_ff + 2'h1;
                  end
               end
            end
            LS_WR_ACK: begin
               sda_drv_ff <= 1'b0;
               bitcnt_ff <= 4'h0;
               state_ff <= LS_WR_BYTE;
            end
            LS_RD_BYTE: begin
               if (bitcnt_ff == BITS_PER_BYTE) begin
                  sda_drv_ff <= 1'b0;
                  state_ff <= LS_RD_ACK;
                  if (byte_idx_ff != 2'h2) begin
                     byte_idx_ff <= byte_idx_ff + 2'h1;
                  end
               end else begin
                  sda_drv_ff <= ~tx_ff[7];
                  tx_ff <= {tx_ff[6:0], 1'b0};
               end
            end
            LS_RD_ACK: begin
               bitcnt_ff <= 4'h0;
               if (mack_ff) begin
                  sda_drv_ff <= ~tx_byte[7];
                  tx_ff <= {tx_byte[6:0], 1'b0};
                  state_ff <= LS_RD_BYTE;
               end else begin
                  state_ff <= LS_IDLE;
               end
            end
            default: state_ff <= LS_IDLE;
         endcase
      end
   end

   // Access window: start to stop, holds off result commits
   always_ff @(posedge clk_link_i or posedge rst_i) begin
      if (rst_i) begin
         busy_ff <= 1'b0;
      end else if (bus_start) begin
         busy_ff <= 1'b1;
      end else if (bus_stop) begin
         busy_ff <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Result crossing from the system domain
   // ----------------------------------------------------------------
   logic res_tgl_ff;
   logic [9:0] res_code_ff;
   logic res_s1_ff, res_s2_ff, res_d_ff;
   logic res_new, commit;
   logic signed [7:0] temp8;

   // Toggle sync; the code word is held steady for a whole conversion
   always_ff @(posedge clk_link_i or posedge rst_i) begin
      if (rst_i) begin
         res_s1_ff <= 1'b0;
         res_s2_ff <= 1'b0;
         res_d_ff <= 1'b0;
      end else begin
         res_s1_ff <= res_tgl_ff;
         res_s2_ff <= res_s1_ff;
         res_d_ff <= res_s2_ff;
      end
   end

   assign res_new = res_s2_ff ^ res_d_ff;
   // drop the result during an access
   assign commit = res_new & ~busy_ff;
   // top eight bits of the new code
   assign temp8 = res_code_ff[9:2];

   // ----------------------------------------------------------------
   // Link domain: registers, flags, alert
   // ----------------------------------------------------------------
   // pointer at temperature; power-on values
   always_ff @(posedge clk_link_i or posedge rst_i) begin
      if (rst_i) begin
         ptr_ff <= PTR_TEMP;
         cfg_ff <= CFG_RESET;
         high_ff <= HIGH_RESET;
         low_ff <= LOW_RESET;
      end else if (wr_done && byte_idx_ff == 2'h0) begin
         ptr_ff <= rx_ff[1:0];
      end else if (wr_done && byte_idx_ff == 2'h1) begin
         case (ptr_ff)
            // Action bits D3 and D2 do not stay set
            PTR_CFG: cfg_ff <= {rx_ff[7:4], 2'b00, rx_ff[1:0]};
            PTR_HIGH: high_ff <= rx_ff;
            PTR_LOW: low_ff <= rx_ff;
            default: ptr_ff <= ptr_ff;
         endcase
      end
   end

   logic cfg_wr, clr_flags;
   assign cfg_wr = wr_done && byte_idx_ff == 2'h1 && ptr_ff == PTR_CFG;
   // reading the second byte clears high and low flags, not alert
   assign clr_flags = (load_first | load_next) && !ara_ff
                      && ptr_ff == PTR_TEMP && byte_idx_ff != 2'h0;

   // Temperature and flags; a set below overrides any clear above
   always_ff @(posedge clk_link_i or posedge rst_i) begin
      if (rst_i) begin
         temp_ff <= TEMP_RESET;
         flags_ff <= '0;
      end else begin
         if (clr_flags) begin
            flags_ff.high <= 1'b0;
            flags_ff.low <= 1'b0;
         end
         if (cfg_wr && rx_ff[3]) begin
            flags_ff.alert <= 1'b0;
         end
         if (commit) begin
            // read-only 10-bit code, set by conversions only
            temp_ff <= res_code_ff;
            if (temp8 > $signed(high_ff)) begin
               flags_ff.alert <= 1'b1;
               flags_ff.high <= 1'b1;
            end
            if (temp8 < $signed(low_ff)) begin
               flags_ff.alert <= 1'b0;
               flags_ff.low <= 1'b1;
            end
         end
      end
   end

   // One-shot request and power-down level toward the system side
   logic os_tgl_ff;
   always_ff @(posedge clk_link_i or posedge rst_i) begin
      if (rst_i) begin
         os_tgl_ff <= 1'b0;
      end else if (cfg_wr && rx_ff[2]) begin
         os_tgl_ff <= ~os_tgl_ff;
      end
   end

   // ----------------------------------------------------------------
   // Pins: both lines only ever sink
   // ----------------------------------------------------------------
   // open drain, low level only
   assign sda_o = 1'b0;
   assign sda_oe_n_o = ~sda_drv_ff;
   assign alert_o = 1'b0;
   // polarity; active high sinks while idle
   assign alert_oe_n_o = cfg_ff.alert_pol ? alert_act : ~alert_act;

   // ----------------------------------------------------------------
   // System domain: conversion scheduler
   // ----------------------------------------------------------------
   logic pd_s1_ff, pd_s2_ff, os_s1_ff, os_s2_ff, os_d_ff;
   logic os_req;
   conv_state_t cv_ff;
   logic [31:0] period_cnt_ff;
   logic [11:0] cv_cnt_ff;
   logic tick;

   // Level and toggle crossings from the link side
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         pd_s1_ff <= 1'b0;
         pd_s2_ff <= 1'b0;
         os_s1_ff <= 1'b0;
         os_s2_ff <= 1'b0;
         os_d_ff <= 1'b0;
      end else begin
         pd_s1_ff <= cfg_ff.power_down_bit;
         pd_s2_ff <= pd_s1_ff;
         os_s1_ff <= os_tgl_ff;
         os_s2_ff <= os_s1_ff;
         os_d_ff <= os_s2_ff;
      end
   end

   assign os_req = os_s2_ff ^ os_d_ff;
   assign tick = !pd_s2_ff && period_cnt_ff == 32'(PERIOD_CYC - 1);

   // Period timer; one-shot restarts it so the schedule resumes
   // automatic period; halted in power-down
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         period_cnt_ff <= 32'h0000_0000;
      end else if (pd_s2_ff || os_req || tick) begin
         period_cnt_ff <= 32'h0000_0000;
      end else begin
         period_cnt_ff <= period_cnt_ff + 32'h0000_0001;
      end
   end

   // Wake, convert, then sleep; in power-down only a one-shot wakes it
   // wake then convert; back to sleep
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         cv_ff <= CV_OFF;
         cv_cnt_ff <= 12'h000;
         res_tgl_ff <= 1'b0;
         res_code_ff <= TEMP_RESET;
      end else begin
         case (cv_ff)
            CV_OFF: begin
               cv_cnt_ff <= 12'h000;
               if (tick || os_req) begin
                  cv_ff <= CV_WAKE;
               end
            end
            CV_WAKE: begin
               if (cv_cnt_ff == 12'(WAKE_CYC - 1)) begin
                  cv_cnt_ff <= 12'h000;
                  cv_ff <= CV_CONV;
               end else begin
                  cv_cnt_ff <= cv_cnt_ff + 12'h001;
               end
            end
            CV_CONV: begin
               if (cv_cnt_ff == 12'(CONV_CYC - 1)) begin
                  cv_cnt_ff <= 12'h000;
                  res_code_ff <= adc_code_i;
                  res_tgl_ff <= ~res_tgl_ff;
                  cv_ff <= CV_OFF;
               end else begin
                  cv_cnt_ff <= cv_cnt_ff + 12'h001;
               end
            end
            default: cv_ff <= CV_OFF;
         endcase
      end
   end

   // Converter power is only on while a conversion is in flight
   assign converter_on_o = cv_ff != CV_OFF;
   assign converting_o = cv_ff == CV_CONV;

endmodule

// file: hw/temp_sensor_pkg.sv
// Shared constants, types and states for the temperature sensor block
package temp_sensor_pkg;

   // ----------------------------------------------------------------
   // Register pointer values
   // ----------------------------------------------------------------
   localparam logic [1:0] PTR_TEMP = 2'h0;
   localparam logic [1:0] PTR_CFG = 2'h1;
   localparam logic [1:0] PTR_HIGH = 2'h2;
   localparam logic [1:0] PTR_LOW = 2'h3;

   // ----------------------------------------------------------------
   // Values after reset
   // ----------------------------------------------------------------
   localparam logic [7:0] CFG_RESET = 8'h40;
   localparam logic [7:0] HIGH_RESET = 8'h7F;
   localparam logic [7:0] LOW_RESET = 8'h80;
   localparam logic [9:0] TEMP_RESET = 10'h000;

   // ----------------------------------------------------------------
   // Serial addresses
   // ----------------------------------------------------------------
   localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h48;
   localparam logic [6:0] ALERT_RESP_ADDR = 7'h0C;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;

   // ----------------------------------------------------------------
   // Timing: figures in their own unit, cycle counts derived
   // ----------------------------------------------------------------
   localparam int SYS_CLK_MHZ = 100;
   localparam int CONV_PERIOD_MS = 800;
   localparam int WAKE_US = 4;
   localparam int CONV_US = 25;
   localparam int CONV_PERIOD_CYC = CONV_PERIOD_MS * 1000 * SYS_CLK_MHZ;
   localparam int WAKE_CYC = WAKE_US * SYS_CLK_MHZ;
   localparam int CONV_CYC = CONV_US * SYS_CLK_MHZ;

   // ----------------------------------------------------------------
   // Configuration register layout
   // ----------------------------------------------------------------
   typedef struct packed {
      logic power_down_bit;
      logic rsv6;
      logic alert_dis;
      logic alert_pol;
      logic alert_rst;
      logic one_shot;
      logic [1:0] rsv;
   } cfg_t;

   // Limit flags carried in the second temperature byte
   typedef struct packed {
      logic alert;
      logic high;
      logic low;
   } flags_t;

   // ----------------------------------------------------------------
   // State machines
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      LS_IDLE = 3'b000,
      LS_ADDR = 3'b001,
      LS_ADDR_ACK = 3'b010,
      LS_WR_BYTE = 3'b011,
      LS_WR_ACK = 3'b100,
      LS_RD_BYTE = 3'b101,
      LS_RD_ACK = 3'b110
   } link_state_t;

   typedef enum logic [1:0] {
      CV_OFF = 2'b00,
      CV_WAKE = 2'b01,
      CV_CONV = 2'b10
   } conv_state_t;

endpackage

// file: tb/bus_host_model.sv
// Behavioural serial bus host driving the sensor's clock and data pins
`timescale 1ns/1ps
module bus_host_model (
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_o
);
   // Quarter bit time; the bench raises it to act as a slow host
   int q_ns = 50;
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   task automatic start_cond();
      sda_o = 1'b1;
      #(q_ns) scl_o = 1'b1;
      #(q_ns) sda_o = 1'b0;
      #(q_ns) scl_o = 1'b0;
   endtask
   task automatic stop_cond();
      #(q_ns) sda_o = 1'b0;
      #(q_ns) scl_o = 1'b1;
      #(q_ns) sda_o = 1'b1;
      #(q_ns);
   endtask
   // Data moves only while the clock is low
   task automatic xfer_bit(input logic b, output logic r);
      #(q_ns) sda_o = b;
      #(q_ns) scl_o = 1'b1;
      #(q_ns) r = sda_i;
      #(q_ns) scl_o = 1'b0;
   endtask
   task automatic xfer_byte(input logic [7:0] d, input logic ack_in,
                            output logic [7:0] r, output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--) begin
         xfer_bit(d[i], b);
         r[i] = b;
      end
      xfer_bit(ack_in, b);
      ack = !b;
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] p,
                     input logic [7:0] d, input int n, output logic ack);
      logic [7:0] r;
      start_cond();
      xfer_byte({a, 1'b0}, 1'b1, r, ack);
      xfer_byte(p, 1'b1, r, ack);
      for (int i = 0; i < n; i++) xfer_byte(d, 1'b1, r, ack);
      stop_cond();
   endtask
   // host acks all but the last byte read
   task automatic rd(input logic [6:0] a, input int n, output logic [7:0] b0,
                     output logic [7:0] b1, output logic ack);
      logic [7:0] r;
      logic k;
      start_cond();
      xfer_byte({a, 1'b1}, 1'b1, r, ack);
      b0 = 8'h00;
      b1 = 8'h00;
      if (ack) begin
         xfer_byte(8'hFF, n == 1, b0, k);
         if (n > 1) xfer_byte(8'hFF, 1'b1, b1, k);
      end
      stop_cond();
   endtask
endmodule

// file: tb/sensor_checker.sv
// Checker for the sensor core pins and conversion timing
`timescale 1ns/1ps
module sensor_checker
   import temp_sensor_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic clk_link_i,
   input wire logic scl_i,
   input wire logic sda_o,
   input wire logic sda_oe_n_o,
   input wire logic alert_o,
   input wire logic converter_on_o,
   input wire logic converting_o
);
   // ------------------------------------------------------------
   // Powered cycle count
   // ------------------------------------------------------------
   // Cleared while off, so each conversion is measured on its own
   int on_cnt_ff;
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         on_cnt_ff <= 0;
      end else begin
         on_cnt_ff <= converter_on_o ? on_cnt_ff + 1 : 0;
      end
   end

   // Wake phase and conversion phase, first cycles of each
   sequence s_wake;
      (converter_on_o && !converting_o) [*8];
   endsequence
   sequence s_convert;
      (converter_on_o && converting_o) [*8];
   endsequence

   a_alert_only_sinks: assert property (@(posedge clk_sys_i)
      disable iff (rst_i) alert_o == 1'b0)
      else $error("alert output drives high");
   a_data_only_sinks: assert property (@(posedge clk_link_i)
      disable iff (rst_i) sda_o == 1'b0)
      else $error("data output drives high");
   a_pull_scl_low: assert property (@(posedge clk_link_i)
      disable iff (rst_i) $fell(sda_oe_n_o) |-> !scl_i)
      else $error("data pulled low while clock high");
   a_wake_length: assert property (@(posedge clk_sys_i)
      disable iff (rst_i) $rose(converting_o) |-> on_cnt_ff == WAKE_CYC)
      else $error("wake phase length wrong");
   a_conv_length: assert property (@(posedge clk_sys_i)
      disable iff (rst_i)
      $fell(converter_on_o) |-> on_cnt_ff == WAKE_CYC + CONV_CYC)
      else $error("powered span length wrong");
   a_conv_in_power: assert property (@(posedge clk_sys_i)
      disable iff (rst_i) converting_o |-> converter_on_o)
      else $error("converting while unpowered");
   a_ends_together: assert property (@(posedge clk_sys_i)
      disable iff (rst_i) $fell(converting_o) |-> $fell(converter_on_o))
      else $error("converter stays on after conversion");
   a_wake_first: assert property (@(posedge clk_sys_i)
      disable iff (rst_i) $rose(converter_on_o) |-> s_wake)
      else $error("wake phase missing");
   a_conv_holds: assert property (@(posedge clk_sys_i)
      disable iff (rst_i) $rose(converting_o) |-> s_convert)
      else $error("conversion phase cut short");
endmodule

bind temp_sensor_access_alert sensor_checker chk (
   .clk_sys_i(clk_sys_i),
   .rst_i(rst_i),
   .clk_link_i(clk_link_i),
   .scl_i(scl_i),
   .sda_o(sda_o),
   .sda_oe_n_o(sda_oe_n_o),
   .alert_o(alert_o),
   .converter_on_o(converter_on_o),
   .converting_o(converting_o)
);

// file: tb/tb.sv
// Self-checking bench for the temperature sensor core
`timescale 1ns/1ps
module tb;
   import temp_sensor_pkg::*;
   // Short schedule keeps the automatic period within the run
   localparam int PER = 5000;
   localparam logic [7:0] P_TEMP = {6'h00, PTR_TEMP};
   localparam logic [7:0] P_CFG = {6'h00, PTR_CFG};
   localparam logic [7:0] P_HIGH = {6'h00, PTR_HIGH};
   localparam logic [7:0] P_LOW = {6'h00, PTR_LOW};
   logic clk_sys_i, clk_link_i, rst_i, scl, host_sda, sda_wire, sda_o;
   logic sda_oe_n, alert_o, alert_oe_n, alert_pin, conv_on, converting;
   logic [9:0] adc_code;
   logic [7:0] b0, b1;
   logic ack;
   int err_count = 0;
   int tests_run = 0;
   int rises = 0;
   int n, t_sys = 0;
   int t_rise[$];

   // Pull-ups on both open-drain lines
   assign sda_wire = host_sda & (sda_oe_n | sda_o);
   assign alert_pin = alert_oe_n | alert_o;

   temp_sensor_access_alert #(.DEV_ADDR(DEV_ADDR_DEFAULT),
      .PERIOD_CYC(PER)) uut (
      .clk_sys_i(clk_sys_i), .rst_i(rst_i), .clk_link_i(clk_link_i),
      .scl_i(scl), .sda_i(sda_wire), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n),
      .alert_o(alert_o), .alert_oe_n_o(alert_oe_n), .adc_code_i(adc_code),
      .converter_on_o(conv_on), .converting_o(converting));
   bus_host_model host (.sda_i(sda_wire), .scl_o(scl), .sda_o(host_sda));

   initial begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end
   initial begin
      clk_link_i = 1'b0;
      #1.7;
      forever #3 clk_link_i = ~clk_link_i;
   end
   // Conversion start times, in system cycles
   always @(posedge clk_sys_i) t_sys++;
   always @(posedge conv_on) begin
      rises++;
      t_rise.push_back(t_sys);
   end

   task automatic check_byte(input string what, input logic [7:0] exp,
                             input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic check_bit(input string what, input logic exp,
                            input logic got);
      check_byte(what, {7'h00, exp}, {7'h00, got});
   endtask
   task automatic set_reg(input logic [7:0] p, input logic [7:0] d);
      host.wr(DEV_ADDR_DEFAULT, p, d, 1, ack);
   endtask
   task automatic get_reg(input logic [7:0] p, input int cnt);
      host.wr(DEV_ADDR_DEFAULT, p, 8'h00, 0, ack);
      host.rd(DEV_ADDR_DEFAULT, cnt, b0, b1, ack);
   endtask
   // Waits out one whole conversion and its commit
   task automatic one_conv();
      int i;
      i = 0;
      while (conv_on !== 1'b1 && i < 20000) begin
         @(posedge clk_sys_i);
         i++;
      end
      while (conv_on !== 1'b0 && i < 20000) begin
         @(posedge clk_sys_i);
         i++;
      end
      check_bit("conversion done", 1'b1, i < 20000);
      repeat (10) @(posedge clk_sys_i);
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // Watchdog well beyond the expected half millisecond
   initial begin
      #900000;
      err_count++;
      $display("CHECK FAILED watchdog expected finish seen timeout");
      give_verdict();
   end

   initial begin
      rst_i = 1'b1;
      adc_code = 10'h000;
      repeat (10) @(posedge clk_sys_i);
      @(negedge clk_sys_i) rst_i = 1'b0;
      repeat (3) @(posedge clk_link_i);
      check_bit("alert pin", 1'b1, alert_pin);
      host.rd(DEV_ADDR_DEFAULT, 2, b0, b1, ack);
      check_byte("temp msb", 8'h00, b0);
      check_byte("temp lsb", 8'h00, b1);
      get_reg(P_CFG, 1);
      check_byte("config", 8'h40, b0);
      get_reg(P_HIGH, 1);
      check_byte("upper", 8'h7F, b0);
      host.rd(DEV_ADDR_DEFAULT, 1, b0, b1, ack);
      check_byte("upper again", 8'h7F, b0);
      get_reg(P_LOW, 1);
      check_byte("lower", 8'h80, b0);
      $display("test reset values done");
      set_reg(P_CFG, 8'h80);
      host.wr(DEV_ADDR_DEFAULT, P_HIGH, 8'h10, 2, ack);
      check_bit("extra byte ack", 1'b0, ack);
      get_reg(P_HIGH, 1);
      check_byte("upper", 8'h10, b0);
      set_reg(P_LOW, 8'h05);
      get_reg(P_LOW, 1);
      check_byte("lower", 8'h05, b0);
      @(negedge clk_sys_i) adc_code = {8'h20, 2'b01};
      n = rises;
      set_reg(P_CFG, 8'h84);
      one_conv();
      check_bit("alert pin", 1'b0, alert_pin);
      get_reg(P_TEMP, 2);
      check_byte("temp msb", 8'h20, b0);
      check_byte("temp lsb", 8'h70, b1);
      host.rd(DEV_ADDR_DEFAULT, 2, b0, b1, ack);
      check_byte("temp lsb", 8'h60, b1);
      repeat (PER + 1000) @(posedge clk_sys_i);
      check_bit("asleep", 1'b1, rises == n + 1);
      $display("test power down one-shot done");
      host.q_ns = 150;
      host.rd(ALERT_RESP_ADDR, 1, b0, b1, ack);
      check_bit("ara ack", 1'b1, ack);
      check_byte("ara addr", {DEV_ADDR_DEFAULT, 1'b0}, b0);
      set_reg(P_CFG, 8'h88);
      check_bit("alert pin", 1'b1, alert_pin);
      host.rd(ALERT_RESP_ADDR, 1, b0, b1, ack);
      check_bit("ara ack", 1'b0, ack);
      host.q_ns = 50;
      set_reg(P_CFG, 8'h90);
      check_bit("alert pin", 1'b0, alert_pin);
      set_reg(P_CFG, 8'hA4);
      one_conv();
      check_bit("alert pin", 1'b1, alert_pin);
      set_reg(P_CFG, 8'h80);
      check_bit("alert pin", 1'b0, alert_pin);
      set_reg(P_CFG, 8'h90);
      check_bit("alert pin", 1'b1, alert_pin);
      @(negedge clk_sys_i) adc_code = {8'h02, 2'b10};
      set_reg(P_CFG, 8'h84);
      one_conv();
      check_bit("alert pin", 1'b1, alert_pin);
      get_reg(P_TEMP, 2);
      check_byte("temp lsb", 8'h98, b1);
      $display("test alert done");
      set_reg(P_CFG, 8'h04);
      one_conv();
      one_conv();
      n = t_rise[$] - t_rise[$-1];
      check_bit("period", 1'b1, n >= PER - 3 && n <= PER + 3);
      @(negedge clk_sys_i) adc_code = 10'h3FC;
      @(posedge conv_on);
      host.start_cond();
      host.xfer_byte({DEV_ADDR_DEFAULT, 1'b0}, 1'b1, b0, ack);
      @(negedge conv_on);
      repeat (20) @(posedge clk_sys_i);
      host.stop_cond();
      get_reg(P_TEMP, 2);
      check_byte("temp held", 8'h02, b0);
      one_conv();
      get_reg(P_TEMP, 2);
      check_byte("temp auto", 8'hFF, b0);
      $display("test automatic mode done");
      give_verdict();
   end
endmodule
